/* src/instrument_tm_packet_builder.sv */
// Telemetry packet builder for the probe and magnetometer instruments
`timescale 1ns/10ps
`include "tm_consts.svh"
module instrument_tm_packet_builder #(
   parameter int unsigned CYCLES_PER_SEC = `CYC_PER_SEC,
   parameter logic [15:0] HK_IDENT = `HK_IDENT_DEFAULT
) (
   // Clock, reset, clock enable
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic clkEn,
   // Per-type generation enables, indexed by tm_pkg::pkt_t
   input wire logic [6:0] genEnable,
   // Housekeeping records and temperature
   input wire logic [47:0] hkRec1,
   input wire logic hkRec1Valid,
   input wire logic [47:0] hkRec2,
   input wire logic hkRec2Valid,
   input wire logic [15:0] tempValue,
   // Science payload fetch
   output logic payActive,
   output tm_pkg::pkt_t payType,
   output logic [12:0] payIndex,
   input wire logic [7:0] payData,
   // Packet byte stream to the interface unit
   output logic [7:0] txData,
   output logic txValid,
   output logic txLast,
   input wire logic txReady,
   // Status
   output logic hkIncomplete
);
   import tm_pkg::*;

   function automatic desc_t descOf(input pkt_t t);
      desc_t d;
      d.pid = `PID_PROBE;
      d.cat = `CAT_PRIVATE;
      d.svc = `SVC_SCI;
      d.sub = `SUB_PROBE_SCI;
      d.sid = `SID_MIN;
      d.len = `LEN_PROBE_MIN;
      d.total = `TOT_PROBE_MIN;
      d.period = `PERIOD_STD_S;
      unique case (t)
         PKT_PROBE_MIN: begin
            d.sid = `SID_MIN;
         end
         PKT_PROBE_NORM: begin
            d.sid = `SID_NORM;
            d.len = `LEN_PROBE_NORM;
            d.total = `TOT_PROBE_NORM;
         end
         PKT_PROBE_BURST: begin
            d.sid = `SID_BURST;
            d.len = `LEN_PROBE_BURST;
            d.total = `TOT_PROBE_BURST;
         end
         PKT_PROBE_HK: begin
            d.cat = `CAT_HK;
            d.svc = `SVC_HK;
            d.sub = `SUB_HK;
            d.sid = `SID_HK;
            d.len = `LEN_PROBE_HK;
            d.total = `TOT_PROBE_HK;
         end
         PKT_MAGN_MIN: begin
            d.pid = `PID_MAGN;
            d.sub = `SUB_MAGN_SCI;
            d.len = `LEN_MAGN_MIN;
            d.total = `TOT_MAGN_MIN;
            d.period = `PERIOD_LONG_S;
         end
         PKT_MAGN_NORM: begin
            d.pid = `PID_MAGN;
            d.sub = `SUB_MAGN_SCI;
            d.sid = `SID_NORM;
            d.len = `LEN_MAGN_NORM;
            d.total = `TOT_MAGN_NORM;
         end
         PKT_MAGN_BURST: begin
            d.pid = `PID_MAGN;
            d.sub = `SUB_MAGN_SCI;
            d.sid = `SID_BURST;
            d.len = `LEN_MAGN_BURST;
            d.total = `TOT_MAGN_BURST;
         end
         default: begin
            d.pid = `PID_PROBE;
         end
      endcase
      return d;
   endfunction : descOf

   // Period timers, one per packet type
   logic [6:0] dueVec;
   genvar gi;
   generate
      for (gi = 0; gi < `NUM_PKT; gi++) begin : g_timer
         period_if pIf ();
         assign pIf.enable = genEnable[gi];
         assign pIf.periodSec = descOf(pkt_t'(gi)).period;
         assign dueVec[gi] = pIf.due;
         period_timer #(
            .CYCLES_PER_SEC(CYCLES_PER_SEC)
         ) u_timer (
            .sys_clk(sys_clk),
            .resetn(resetn),
            .clkEn(clkEn),
            .pi(pIf.tmr)
         );
      end
   endgenerate

   // Housekeeping record latches
   logic [47:0] hk1;
   logic [47:0] next_hk1;
   logic [47:0] hk2;
   logic [47:0] next_hk2;
   logic have1;
   logic next_have1;
   logic have2;
   logic next_have2;
   logic [6:0] launch;

   always_comb begin
      next_hk1 = hkRec1Valid ? hkRec1 : hk1;
      next_hk2 = hkRec2Valid ? hkRec2 : hk2;
      // A record arriving on the launch cycle counts for the next period
      next_have1 = hkRec1Valid | (have1 & ~launch[PKT_PROBE_HK]);
      next_have2 = hkRec2Valid | (have2 & ~launch[PKT_PROBE_HK]);
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         hk1 <= 48'h0000_0000_0000;
         hk2 <= 48'h0000_0000_0000;
         have1 <= 1'b0;
         have2 <= 1'b0;
      end else if (clkEn) begin
         hk1 <= next_hk1;
         hk2 <= next_hk2;
         have1 <= next_have1;
         have2 <= next_have2;
      end
   end

   // Pending requests: a due tick wins over the launch that clears it
   logic [6:0] pending;
   logic [6:0] next_pending;

   always_comb begin
      next_pending = genEnable & (dueVec | (pending & ~launch));
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         pending <= 7'h00;
      end else if (clkEn) begin
         pending <= next_pending;
      end
   end

   // Framer
   state_t state;
   state_t next_state;
   pkt_t curType;
   pkt_t next_curType;
   logic [12:0] byteIdx;
   logic [12:0] next_byteIdx;
   logic [15:0] seqCnt;
   logic [15:0] next_seqCnt;
   logic [7:0] next_txData;
   logic next_txValid;
   logic next_txLast;
   logic next_payActive;
   pkt_t next_payType;
   logic [12:0] next_payIndex;
   logic next_hkIncomplete;
   logic slotFree;
   desc_t cur;
   logic [127:0] hkImage;
   logic [3:0] hkSel;
   logic [7:0] curByte;

   assign slotFree = !txValid || txReady;
   assign cur = descOf(curType);
   assign hkImage = {hk1, hk2, tempValue, HK_IDENT};
   assign hkSel = 4'(byteIdx - `DATA_START);

   always_comb begin
      curByte = 8'h00;
      if (byteIdx >= `DATA_START) begin
         if (curType == PKT_PROBE_HK) begin
            curByte = hkImage[{`HK_LAST_BYTE - hkSel, 3'b000} +: 8];
         end else begin
            curByte = payData;
         end
      end else begin
         unique case (byteIdx[3:0])
            `B_PID: curByte = cur.pid;
            `B_CAT: curByte = cur.cat;
            `B_LEN_HI: curByte = cur.len[15:8];
            `B_LEN_LO: curByte = cur.len[7:0];
            `B_SEQ_HI: curByte = seqCnt[15:8];
            `B_SEQ_LO: curByte = seqCnt[7:0];
            `B_SVC: curByte = cur.svc;
            `B_SUB: curByte = cur.sub;
            `B_SID: curByte = cur.sid;
            default: curByte = 8'h00;
         endcase
      end
   end

   always_comb begin
      next_state = state;
      next_curType = curType;
      next_byteIdx = byteIdx;
      next_seqCnt = seqCnt;
      next_txData = txData;
      next_txValid = txValid;
      next_txLast = txLast;
      next_payActive = payActive;
      next_payType = payType;
      next_payIndex = payIndex;
      next_hkIncomplete = hkIncomplete;
      launch = 7'h00;
      unique case (state)
         ST_IDLE: begin
            // Lowest index wins; a type disabled this cycle is not started
            for (int i = `NUM_PKT - 1; i >= 0; i--) begin
               if (pending[i] && genEnable[i]) begin
                  next_curType = pkt_t'(i);
               end
            end
            if ((pending & genEnable) != 7'h00) begin
               launch[next_curType] = 1'b1;
               next_state = ST_SEND;
               next_byteIdx = 13'h0000;
               next_payType = next_curType;
               if (next_curType == PKT_PROBE_HK) begin
                  next_hkIncomplete = !(have1 && have2);
               end
            end
         end
         ST_SEND: begin
            if (slotFree) begin
               next_txData = curByte;
               next_txValid = 1'b1;
               next_txLast = (byteIdx == cur.total - 13'h0001);
               if (next_txLast) begin
                  next_state = ST_DRAIN;
                  next_payActive = 1'b0;
                  next_seqCnt = seqCnt + 16'h0001;
               end else begin
                  next_byteIdx = byteIdx + 13'h0001;
                  // Fetch index leads so payData matches the next load
                  next_payActive = (next_byteIdx >= `DATA_START) &&
                     (curType != PKT_PROBE_HK);
                  next_payIndex = next_byteIdx - `DATA_START;
               end
            end
         end
         ST_DRAIN: begin
            if (txReady) begin
               next_txValid = 1'b0;
               next_txLast = 1'b0;
               next_state = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         state <= ST_IDLE;
         curType <= PKT_PROBE_MIN;
         byteIdx <= 13'h0000;
         seqCnt <= 16'h0000;
         txData <= 8'h00;
         txValid <= 1'b0;
         txLast <= 1'b0;
         payActive <= 1'b0;
         payType <= PKT_PROBE_MIN;
         payIndex <= 13'h0000;
         hkIncomplete <= 1'b0;
      end else if (clkEn) begin
         state <= next_state;
         curType <= next_curType;
         byteIdx <= next_byteIdx;
         seqCnt <= next_seqCnt;
         txData <= next_txData;
         txValid <= next_txValid;
         txLast <= next_txLast;
         payActive <= next_payActive;
         payType <= next_payType;
         payIndex <= next_payIndex;
         hkIncomplete <= next_hkIncomplete;
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);

   sequence sStart(pkt_t t);
      (state == ST_IDLE && clkEn) ##1 (state == ST_SEND && curType == t &&
         byteIdx == 13'h0000);
   endsequence

   sequence sLoad(logic [3:0] pos);
      state == ST_SEND && clkEn && slotFree && byteIdx == {9'h000, pos};
   endsequence

   chk_probe_min_size: assert property (sStart(PKT_PROBE_MIN) |->
      (cur.total == 13'h0022 && cur.sid == 8'h01 && cur.pid == 8'h57))
      else $error("probe minimum packet descriptor wrong");
   chk_probe_norm_size: assert property (sStart(PKT_PROBE_NORM) |->
      (cur.len == 16'h00d0 && cur.sid == 8'h02 && cur.sub == 8'h03))
      else $error("probe normal packet descriptor wrong");
   chk_probe_burst_size: assert property (sStart(PKT_PROBE_BURST) |->
      (cur.len == 16'h04ba && cur.sid == 8'h03 && cur.svc == 8'h14))
      else $error("probe burst packet descriptor wrong");
   chk_hk_header_fields: assert property (sStart(PKT_PROBE_HK) |->
      (cur.cat == 8'h04 && cur.svc == 8'h03 && cur.sub == 8'h19 &&
      cur.len == 16'h001a))
      else $error("housekeeping header fields wrong");
   chk_magn_min_size: assert property (sStart(PKT_MAGN_MIN) |->
      (cur.len == 16'h0028 && cur.pid == 8'h58 && cur.period == 9'h100))
      else $error("magnetometer minimum descriptor wrong");
   chk_magn_norm_size: assert property (sStart(PKT_MAGN_NORM) |->
      (cur.len == 16'h00d0 && cur.sub == 8'h02 && cur.period == 9'h020))
      else $error("magnetometer normal descriptor wrong");
   chk_magn_burst_size: assert property (sStart(PKT_MAGN_BURST) |->
      (cur.len == 16'h1008 && cur.total == 13'h100e))
      else $error("magnetometer burst descriptor wrong");
   chk_len_byte_pair: assert property (sLoad(`B_LEN_HI) ##1
      (clkEn && slotFree && byteIdx == 13'h0003) |=>
      (txData == $past(cur.len[7:0]) && txValid))
      else $error("length low byte not sent after high byte");
   chk_last_byte_count: assert property ((state == ST_SEND && clkEn &&
      slotFree && byteIdx == cur.total - 13'h0001) |=>
      (txLast && txValid && state == ST_DRAIN))
      else $error("packet end not marked at its byte count");
   chk_hk_ident_tail: assert property ((state == ST_SEND && clkEn &&
      slotFree && curType == PKT_PROBE_HK && byteIdx == 13'h001f) |=>
      (txData == HK_IDENT[7:0] && txLast))
      else $error("housekeeping identifier not last");
   chk_hk_record_once: assert property ((clkEn && launch[PKT_PROBE_HK] &&
      !hkRec1Valid && !hkRec2Valid) |=> (!have1 && !have2))
      else $error("housekeeping records reused across periods");
   chk_disabled_silent: assert property ((clkEn && genEnable == 7'h00 &&
      state == ST_IDLE) |=> (state == ST_IDLE && pending == 7'h00))
      else $error("packet started while all types disabled");
   chk_reset_clear: assert property (@(posedge sys_clk) disable iff (1'b0)
      (!resetn) |=> (pending == 7'h00 && !txValid))
      else $error("pending flags not cleared by reset");

endmodule : instrument_tm_packet_builder

/* src/period_if.sv */
// Link between the builder and one generation period timer
`timescale 1ns/10ps
interface period_if;
   logic enable;
   logic [8:0] periodSec;
   logic due;
   modport ctl (output enable, output periodSec, input due);
   modport tmr (input enable, input periodSec, output due);
endinterface : period_if

/* src/period_timer.sv */
// Per-type generation period timer with restart on enable
`timescale 1ns/10ps
`include "tm_consts.svh"
module period_timer #(
   parameter int unsigned CYCLES_PER_SEC = `CYC_PER_SEC
) (
   // Clock and control
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic clkEn,
   // Builder side
   period_if.tmr pi
);
   logic [31:0] cycCnt;
   logic [31:0] next_cycCnt;
   logic [8:0] secCnt;
   logic [8:0] next_secCnt;
   logic due;
   logic next_due;
   logic [31:0] cycLast;

   assign cycLast = 32'(CYCLES_PER_SEC - 1);

   always_comb begin
      next_cycCnt = cycCnt;
      next_secCnt = secCnt;
      next_due = 1'b0;
      // Counters sit at zero while disabled, so a new enable restarts them
      if (!pi.enable) begin
         next_cycCnt = 32'h0000_0000;
         next_secCnt = 9'h000;
      end else if (cycCnt == cycLast) begin
         next_cycCnt = 32'h0000_0000;
         if (secCnt == pi.periodSec - 9'h001) begin
            next_secCnt = 9'h000;
            next_due = 1'b1;
         end else begin
            next_secCnt = secCnt + 9'h001;
         end
      end else begin
         next_cycCnt = cycCnt + 32'h0000_0001;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         cycCnt <= 32'h0000_0000;
         secCnt <= 9'h000;
         due <= 1'b0;
      end else if (clkEn) begin
         cycCnt <= next_cycCnt;
         secCnt <= next_secCnt;
         due <= next_due;
      end
   end

   assign pi.due = due;

   chk_restart_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
      (clkEn && !pi.enable) |=> (secCnt == 9'h000 && cycCnt == 32'h0000_0000))
      else $error("period timer not held at zero while disabled");

endmodule : period_timer

/* src/tm_consts.svh */
// Named constants for the instrument telemetry packet builder
`ifndef TM_CONSTS_SVH
`define TM_CONSTS_SVH

`define NUM_PKT 7

// Packet layout: 6 header bytes, then 10 data field header bytes
`define PKT_HDR_LEN 13'h0006
`define DATA_START 13'h0010
`define B_PID 4'h0
`define B_CAT 4'h1
`define B_LEN_HI 4'h2
`define B_LEN_LO 4'h3
`define B_SEQ_HI 4'h4
`define B_SEQ_LO 4'h5
`define B_SVC 4'h6
`define B_SUB 4'h7
`define B_SID 4'h8

// Header field values
`define PID_PROBE 8'h57
`define PID_MAGN 8'h58
`define CAT_PRIVATE 8'h0c
`define CAT_HK 8'h04
`define SVC_SCI 8'h14
`define SVC_HK 8'h03
`define SUB_PROBE_SCI 8'h03
`define SUB_MAGN_SCI 8'h02
`define SUB_HK 8'h19
`define SID_MIN 8'h01
`define SID_NORM 8'h02
`define SID_BURST 8'h03
`define SID_HK 8'h01

// Data field length values (payload bytes plus 10)
`define LEN_PROBE_MIN 16'h001c
`define LEN_PROBE_NORM 16'h00d0
`define LEN_PROBE_BURST 16'h04ba
`define LEN_PROBE_HK 16'h001a
`define LEN_MAGN_MIN 16'h0028
`define LEN_MAGN_NORM 16'h00d0
`define LEN_MAGN_BURST 16'h1008

// Whole packet byte counts (length value plus 6)
`define TOT_PROBE_MIN 13'h0022
`define TOT_PROBE_NORM 13'h00d6
`define TOT_PROBE_BURST 13'h04c0
`define TOT_PROBE_HK 13'h0020
`define TOT_MAGN_MIN 13'h002e
`define TOT_MAGN_NORM 13'h00d6
`define TOT_MAGN_BURST 13'h100e

// Generation periods in seconds
`define PERIOD_STD_S 9'h020
`define PERIOD_LONG_S 9'h100

// Timing: one second in clock cycles at 50 MHz
`define SEC_NS 1000000000
`define CLK_PERIOD_NS 20
`define CYC_PER_SEC (`SEC_NS / `CLK_PERIOD_NS)

// Housekeeping payload offsets within the 16-byte image
`define HK_LAST_BYTE 4'hf
`define HK_IDENT_DEFAULT 16'h0a5a

`endif

/* src/tm_pkg.sv */
// Types shared by the telemetry packet builder
package tm_pkg;
`include "tm_consts.svh"

   typedef enum logic [2:0] {
      PKT_PROBE_MIN,
      PKT_PROBE_NORM,
      PKT_PROBE_BURST,
      PKT_PROBE_HK,
      PKT_MAGN_MIN,
      PKT_MAGN_NORM,
      PKT_MAGN_BURST
   } pkt_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SEND,
      ST_DRAIN
   } state_t;

   typedef struct packed {
      logic [7:0] pid;
      logic [7:0] cat;
      logic [7:0] svc;
      logic [7:0] sub;
      logic [7:0] sid;
      logic [15:0] len;
      logic [12:0] total;
      logic [8:0] period;
   } desc_t;

endpackage : tm_pkg

/* verif/instrument_tm_packet_builder_test.sv */
// Self-checking bench for the telemetry packet builder
`timescale 1ns/10ps
module instrument_tm_packet_builder_test;
   import tm_pkg::*;
   localparam int unsigned CPS = 4;
   localparam int unsigned LIMIT = 40000;
   localparam logic [15:0] IDENT = 16'h3c96;
   localparam logic [47:0] R1 = 48'h1357_9bdf_2468;
   localparam logic [47:0] R2 = 48'hace0_8642_fdb9;
   localparam logic [15:0] TEMP = 16'h7e01;
   localparam logic [127:0] HKIMG = {R1, R2, TEMP, IDENT};
   logic [7:0] expPid [7] = '{8'h57, 8'h57, 8'h57, 8'h57, 8'h58, 8'h58, 8'h58};
   logic [7:0] expCat [7] = '{8'h0c, 8'h0c, 8'h0c, 8'h04, 8'h0c, 8'h0c, 8'h0c};
   logic [7:0] expSvc [7] = '{8'h14, 8'h14, 8'h14, 8'h03, 8'h14, 8'h14, 8'h14};
   logic [7:0] expSub [7] = '{8'h03, 8'h03, 8'h03, 8'h19, 8'h02, 8'h02, 8'h02};
   logic [7:0] expSid [7] = '{8'h01, 8'h02, 8'h03, 8'h01, 8'h01, 8'h02, 8'h03};
   logic [15:0] expLen [7] = '{16'h001c, 16'h00d0, 16'h04ba, 16'h001a,
      16'h0028, 16'h00d0, 16'h1008};
   logic [8:0] expPer [7] = '{9'h020, 9'h020, 9'h020, 9'h020, 9'h100,
      9'h020, 9'h020};
   logic sys_clk, resetn, clkEn, hkRec1Valid, hkRec2Valid, stall;
   logic [6:0] genEnable;
   logic [47:0] hkRec1, hkRec2;
   logic [15:0] tempValue, lastSeq;
   logic payActive, txValid, txLast, txReady, hkIncomplete, haveSeq;
   logic [12:0] payIndex;
   logic [7:0] payData, txData;
   pkt_t payType;
   int unsigned errors = 0;
   int unsigned check_count = 0;
   int unsigned cycles = 0;

   instrument_tm_packet_builder #(.CYCLES_PER_SEC(CPS), .HK_IDENT(IDENT))
   u_dut (.sys_clk(sys_clk), .resetn(resetn), .clkEn(clkEn),
      .genEnable(genEnable), .hkRec1(hkRec1), .hkRec1Valid(hkRec1Valid),
      .hkRec2(hkRec2), .hkRec2Valid(hkRec2Valid), .tempValue(tempValue),
      .payActive(payActive), .payType(payType), .payIndex(payIndex),
      .payData(payData), .txData(txData), .txValid(txValid),
      .txLast(txLast), .txReady(txReady), .hkIncomplete(hkIncomplete));

   tm_sink_model u_sink (.sys_clk(sys_clk), .resetn(resetn), .stall(stall),
      .payActive(payActive), .payIndex(payIndex), .payData(payData),
      .txData(txData), .txValid(txValid), .txLast(txLast),
      .txReady(txReady));

   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   task automatic results();
      $display("comparisons %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : results

   // Hang guard well above the longest expected run
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         errors++;
         $display("wrong value run length expected end seen timeout");
         results();
      end
   end

   task automatic check(input string what, input logic [15:0] exp,
      input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic wait_pkt(input int unsigned n0, input int unsigned lim);
      int unsigned i;
      i = 0;
      while (u_sink.pktCount == n0 && i < lim) begin
         @(negedge sys_clk);
         i++;
      end
      check("packet seen", 16'h0001, 16'(u_sink.pktCount != n0));
   endtask : wait_pkt

   // Waits for a quiet stream so a late launch cannot leak into the next test
   task automatic drain();
      int unsigned q;
      q = 0;
      for (int i = 0; i < 9000 && q < 12; i++) begin
         @(negedge sys_clk);
         q = (txValid === 1'b1) ? 0 : q + 1;
      end
      u_sink.rxBytes.delete();
   endtask : drain

   task automatic give_records();
      repeat (30) @(negedge sys_clk);
      hkRec1 = R1;
      hkRec1Valid = 1'b1;
      @(negedge sys_clk);
      hkRec1 = ~R1;
      hkRec1Valid = 1'b0;
      repeat (5) @(negedge sys_clk);
      hkRec2 = R2;
      hkRec2Valid = 1'b1;
      @(negedge sys_clk);
      hkRec2 = ~R2;
      hkRec2Valid = 1'b0;
   endtask : give_records

   task automatic check_pkt(input int t);
      int unsigned n;
      logic [15:0] seq;
      logic [7:0] exp;
      n = u_sink.rxBytes.size();
      check("total bytes", expLen[t] + 16'h0006, 16'(n));
      check("payload type", 16'(t), 16'(payType));
      if (n < 16) return;
      check("process id", expPid[t], u_sink.rxBytes[0]);
      check("category", expCat[t], u_sink.rxBytes[1]);
      check("length", expLen[t], {u_sink.rxBytes[2], u_sink.rxBytes[3]});
      check("service", expSvc[t], u_sink.rxBytes[6]);
      check("subtype", expSub[t], u_sink.rxBytes[7]);
      check("structure", expSid[t], u_sink.rxBytes[8]);
      seq = {u_sink.rxBytes[4], u_sink.rxBytes[5]};
      if (haveSeq) check("sequence", lastSeq + 16'h0001, seq);
      lastSeq = seq;
      haveSeq = 1'b1;
      for (int k = 9; k < 16; k++) check("spare", 16'h0000, u_sink.rxBytes[k]);
      for (int k = 16; k < n; k++) begin
         exp = (t == 3) ? HKIMG[127 - 8 * (k - 16) -: 8] : 8'(k - 16) ^ 8'h5a;
         check("payload", exp, u_sink.rxBytes[k]);
      end
   endtask : check_pkt

   task automatic run_type(input int t, input bit pre);
      int unsigned p, n0, t0;
      p = CPS * expPer[t];
      if (pre) begin
         genEnable[t] = 1'b1;
         repeat (p - 28) @(negedge sys_clk);
         genEnable[t] = 1'b0;
         repeat (p) @(negedge sys_clk);
         check("bytes while off", 16'h0000, 16'(u_sink.rxBytes.size()));
      end
      n0 = u_sink.pktCount;
      t0 = u_sink.cycle;
      genEnable[t] = 1'b1;
      if (t == 3) give_records();
      wait_pkt(n0, p + 9000);
      check("early start", 16'h0000, 16'(u_sink.startCycle < t0 + p));
      check("late start", 16'h0000, 16'(u_sink.startCycle > t0 + p + 8));
      check_pkt(t);
      if (t == 3) check("hk incomplete", 16'h0000, 16'(hkIncomplete));
      genEnable[t] = 1'b0;
      drain();
   endtask : run_type

   // Freezing the clock enable mid-period must also hold the period timer
   task automatic hk_missing();
      int unsigned n0, t0;
      n0 = u_sink.pktCount;
      t0 = u_sink.cycle;
      genEnable[3] = 1'b1;
      repeat (50) @(negedge sys_clk);
      clkEn = 1'b0;
      repeat (200) @(negedge sys_clk);
      check("frozen bytes", 16'h0000, 16'(u_sink.rxBytes.size()));
      clkEn = 1'b1;
      wait_pkt(n0, 300);
      t0 = t0 + CPS * expPer[3] + 200;
      check("frozen start", 16'h0000, 16'(u_sink.startCycle < t0));
      check("hk incomplete", 16'h0001, 16'(hkIncomplete));
      check("hk length", 16'h0020, 16'(u_sink.rxBytes.size()));
      genEnable[3] = 1'b0;
      drain();
   endtask : hk_missing

   task automatic check_idle();
      check("valid after reset", 16'h0000, 16'(txValid));
      check("fetch after reset", 16'h0000, 16'(payActive));
      repeat (300) @(negedge sys_clk);
      check("bytes none enabled", 16'h0000, 16'(u_sink.rxBytes.size()));
   endtask : check_idle

   initial begin
      resetn = 1'b0;
      clkEn = 1'b1;
      stall = 1'b0;
      genEnable = 7'h00;
      hkRec1 = ~R1;
      hkRec2 = ~R2;
      hkRec1Valid = 1'b0;
      hkRec2Valid = 1'b0;
      tempValue = TEMP;
      haveSeq = 1'b0;
      lastSeq = 16'h0000;
      repeat (10) @(negedge sys_clk);
      resetn = 1'b1;
      check_idle();
      for (int t = 0; t < 7; t++) begin
         // Long packets run against a sink that stalls every other cycle
         stall = (t == 2 || t == 6);
         run_type(t, t == 3 || t == 4);
      end
      hk_missing();
      results();
   end
endmodule : instrument_tm_packet_builder_test

/* verif/tm_sink_model.sv */
// Interface unit model: packet byte sink and science payload source
`timescale 1ns/10ps
module tm_sink_model (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Bench control
   input wire logic stall,
   // Payload fetch
   input wire logic payActive,
   input wire logic [12:0] payIndex,
   output logic [7:0] payData,
   // Packet byte stream
   input wire logic [7:0] txData,
   input wire logic txValid,
   input wire logic txLast,
   output logic txReady
);
   logic [7:0] rxBytes [$];
   int unsigned cycle = 0;
   int unsigned startCycle = 0;
   int unsigned pktCount = 0;
   // Outside a fetch the pattern is inverted so a stale byte never matches
   assign payData = payActive ? (payIndex[7:0] ^ 8'h5a) :
      ~(payIndex[7:0] ^ 8'h5a);
   initial txReady = 1'b1;
   always @(negedge sys_clk) begin
      txReady <= stall ? ~txReady : 1'b1;
   end
   always @(posedge sys_clk) begin
      cycle <= cycle + 1;
      if (resetn && txValid && txReady) begin
         if (rxBytes.size() == 0) startCycle = cycle;
         rxBytes.push_back(txData);
         if (txLast) pktCount <= pktCount + 1;
      end
   end
endmodule : tm_sink_model
